// ---- verilog/dcf_map.vh ----
// Constants for the dual-strobe nine-bit first-in first-out buffer
//
// Contract
// - Clear held low returns write and read pointers to location zero.
// - Clear drives full and almost-full high, empty and almost-empty low.
// - Clear zeroes the output register and restores the four offset defaults.
// - Writes start on push edges; full and almost-full change only on push edges.
// - Works with independent push and pop edges or with coincident ones.
// - Programmable mode: first write enable low with load high stores a word each push edge.
// - Words are stored in consecutive locations, independent of reads.
// - Full low ignores write enables; a read later releases full high.
// - Both pop enables low move the next word into the output register.
// - Either pop enable high holds the output register.
// - Empty low ignores pop enables; a completed write raises empty again.
// - Empty and almost-empty change only on pop edges.
// - Output drive control low presents the output register, high floats it.
// - Dual-purpose pin level during clear selects dual-enable or load mode.
// - Dual-enable mode writes only with first enable low and second high.
// - Programmable mode provides four eight-bit offset registers, writable and readable.
// - Load writes offsets cyclically: empty low, empty high, full low, full high.
// - Raising load keeps sequence position; load with enable high does nothing.
// - Load low with both pop enables low reads offsets in the same order.
// - Full goes low once stored words equal the depth.
// - Empty goes low whenever the read pointer equals the write pointer.
// - Both offsets default to seven after clear.
// - Almost-full low when words reach depth minus full offset, until full.
// - Almost-empty low while words at most the empty offset, high above.
`ifndef DCF_MAP_VH
`define DCF_MAP_VH
`define DCF_DATA_W 9
`define DCF_ADDR_W 8
`define DCF_CNT_W 9
`define DCF_DEPTH 9'h100
`define DCF_OFS_W 8
`define DCF_OFS_DEFAULT 8'h07
`define DCF_OFS_ZERO 8'h00
`define DCF_SEL_EMPTY_LO 2'h0
`define DCF_SEL_EMPTY_HI 2'h1
`define DCF_SEL_FULL_LO 2'h2
`define DCF_SEL_FULL_HI 2'h3
`define DCF_SEL_STEP 2'h1
`define DCF_PTR_STEP 9'h001
`define DCF_DATA_ZERO 9'h000
`define DCF_PTR_ZERO 9'h000
`endif

// ---- verilog/dcf_store.v ----
// Storage array of the buffer, one write port and one asynchronous read port
`timescale 1ns/1ps
`default_nettype none
`include "dcf_map.vh"
module dcf_store (
  // Clock
  input wire sys_clk_i,
  // Write port
  input wire wr_en_i,
  input wire [`DCF_ADDR_W-1:0] wr_addr_i,
  input wire [`DCF_DATA_W-1:0] wr_data_i,
  // Read port
  input wire [`DCF_ADDR_W-1:0] rd_addr_i,
  output wire [`DCF_DATA_W-1:0] rd_data_o
);
  reg [`DCF_DATA_W-1:0] mem [0:(1<<`DCF_ADDR_W)-1];

  always @(posedge sys_clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  assign rd_data_o = mem[rd_addr_i];
endmodule // dcf_store
`default_nettype wire

// ---- verilog/dcf_offsets.v ----
// Four offset registers with cyclic load and read sequencing
`timescale 1ns/1ps
`default_nettype none
`include "dcf_map.vh"
module dcf_offsets (
  // Clock and reset
  input wire sys_clk_i,
  input wire rst_i,
  input wire clear_n_i,
  // Access strobes
  input wire load_i,
  input wire fetch_i,
  input wire [`DCF_OFS_W-1:0] load_data_i,
  // Values
  output wire [`DCF_OFS_W-1:0] fetch_data_o,
  output wire [2*`DCF_OFS_W-1:0] empty_ofs_o,
  output wire [2*`DCF_OFS_W-1:0] full_ofs_o
);
  reg [`DCF_OFS_W-1:0] ofs_reg [0:3];
  reg [1:0] load_sel_reg;
  reg [1:0] fetch_sel_reg;

  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ofs_reg[`DCF_SEL_EMPTY_LO] <= `DCF_OFS_DEFAULT;
      ofs_reg[`DCF_SEL_EMPTY_HI] <= `DCF_OFS_ZERO;
      ofs_reg[`DCF_SEL_FULL_LO] <= `DCF_OFS_DEFAULT;
      ofs_reg[`DCF_SEL_FULL_HI] <= `DCF_OFS_ZERO;
      load_sel_reg <= `DCF_SEL_EMPTY_LO;
      fetch_sel_reg <= `DCF_SEL_EMPTY_LO;
    end else if (!clear_n_i) begin
      ofs_reg[`DCF_SEL_EMPTY_LO] <= `DCF_OFS_DEFAULT;
      ofs_reg[`DCF_SEL_EMPTY_HI] <= `DCF_OFS_ZERO;
      ofs_reg[`DCF_SEL_FULL_LO] <= `DCF_OFS_DEFAULT;
      ofs_reg[`DCF_SEL_FULL_HI] <= `DCF_OFS_ZERO;
      load_sel_reg <= `DCF_SEL_EMPTY_LO;
      fetch_sel_reg <= `DCF_SEL_EMPTY_LO;
    end else begin
      if (load_i) begin
        ofs_reg[load_sel_reg] <= load_data_i;
        load_sel_reg <= load_sel_reg + `DCF_SEL_STEP;
      end
      if (fetch_i) begin
        fetch_sel_reg <= fetch_sel_reg + `DCF_SEL_STEP;
      end
    end
  end

  assign fetch_data_o = ofs_reg[fetch_sel_reg];
  assign empty_ofs_o = {ofs_reg[`DCF_SEL_EMPTY_HI], ofs_reg[`DCF_SEL_EMPTY_LO]};
  assign full_ofs_o = {ofs_reg[`DCF_SEL_FULL_HI], ofs_reg[`DCF_SEL_FULL_LO]};
endmodule // dcf_offsets
`default_nettype wire

// ---- verilog/dcf_top.v ----
// Nine-bit first-in first-out buffer with push and pop edge strobes and flags
`timescale 1ns/1ps
`default_nettype none
`include "dcf_map.vh"
module dcf_top (
  // Clock and reset
  input wire sys_clk_i,
  input wire rst_i,
  input wire fifo_clear_n_i,
  // Push side
  input wire push_edge_i,
  input wire push_enable_n_i,
  input wire second_enable_or_load_i,
  input wire [`DCF_DATA_W-1:0] write_data_i,
  output reg full_flag_n_o,
  output reg almost_full_n_o,
  // Pop side
  input wire pop_edge_i,
  input wire pop_enable_a_n_i,
  input wire pop_enable_b_n_i,
  input wire out_drive_n_i,
  output reg [`DCF_DATA_W-1:0] read_data_o,
  output reg read_data_oe_o,
  output reg empty_flag_n_o,
  output reg almost_empty_n_o,
  // Mode
  output reg dual_enable_mode_o
);
  reg [`DCF_CNT_W-1:0] wr_ptr_reg;
  reg [`DCF_CNT_W-1:0] rd_ptr_reg;
  reg [`DCF_DATA_W-1:0] out_reg;
  wire [`DCF_DATA_W-1:0] store_rd_data;
  wire [`DCF_OFS_W-1:0] ofs_fetch_data;
  wire [2*`DCF_OFS_W-1:0] empty_ofs;
  wire [2*`DCF_OFS_W-1:0] full_ofs;
  wire [`DCF_CNT_W-1:0] empty_thr;
  wire [`DCF_CNT_W-1:0] full_thr;
  wire pin_high;
  wire load_active;
  wire push_ok;
  wire pop_req;
  wire do_push;
  wire do_pop;
  wire ofs_load;
  wire ofs_fetch;
  wire [`DCF_CNT_W-1:0] wr_ptr_next;
  wire [`DCF_CNT_W-1:0] rd_ptr_next;
  wire [`DCF_CNT_W-1:0] count_next;

  // Word count between two pointers
  function [`DCF_CNT_W-1:0] words;
    input [`DCF_CNT_W-1:0] wp;
    input [`DCF_CNT_W-1:0] rp;
    begin
      words = wp - rp;
    end
  endfunction

  // Mode decode and access qualification
  assign pin_high = second_enable_or_load_i;
  assign load_active = !dual_enable_mode_o && !pin_high;
  assign push_ok = !push_enable_n_i && pin_high;
  assign pop_req = !pop_enable_a_n_i && !pop_enable_b_n_i;
  assign do_push = push_edge_i && push_ok && full_flag_n_o;
  assign do_pop = pop_edge_i && pop_req && empty_flag_n_o && !load_active;
  assign ofs_load = push_edge_i && load_active && !push_enable_n_i;
  assign ofs_fetch = pop_edge_i && load_active && pop_req;

  // Pointers after this cycle; both sides may move together
  assign wr_ptr_next = do_push ? wr_ptr_reg + `DCF_PTR_STEP : wr_ptr_reg;
  assign rd_ptr_next = do_pop ? rd_ptr_reg + `DCF_PTR_STEP : rd_ptr_reg;
  assign count_next = words(wr_ptr_next, rd_ptr_next);

  // Thresholds from the offset registers
  assign empty_thr = {1'b0, empty_ofs[`DCF_CNT_W-2:0]};
  assign full_thr = `DCF_DEPTH - {1'b0, full_ofs[`DCF_CNT_W-2:0]};

  dcf_store u_store (
    .sys_clk_i(sys_clk_i),
    .wr_en_i(do_push),
    .wr_addr_i(wr_ptr_reg[`DCF_ADDR_W-1:0]),
    .wr_data_i(write_data_i),
    .rd_addr_i(rd_ptr_reg[`DCF_ADDR_W-1:0]),
    .rd_data_o(store_rd_data)
  );

  dcf_offsets u_offsets (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .clear_n_i(fifo_clear_n_i),
    .load_i(ofs_load),
    .fetch_i(ofs_fetch),
    .load_data_i(write_data_i[`DCF_OFS_W-1:0]),
    .fetch_data_o(ofs_fetch_data),
    .empty_ofs_o(empty_ofs),
    .full_ofs_o(full_ofs)
  );

  // Mode caught while clear is held low
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dual_enable_mode_o <= 1'b0;
    end else if (!fifo_clear_n_i) begin
      dual_enable_mode_o <= second_enable_or_load_i;
    end
  end

  // Pointers, flags and output register
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_reg <= `DCF_PTR_ZERO;
      rd_ptr_reg <= `DCF_PTR_ZERO;
      full_flag_n_o <= 1'b1;
      almost_full_n_o <= 1'b1;
      empty_flag_n_o <= 1'b0;
      almost_empty_n_o <= 1'b0;
      out_reg <= `DCF_DATA_ZERO;
    end else if (!fifo_clear_n_i) begin
      wr_ptr_reg <= `DCF_PTR_ZERO;
      rd_ptr_reg <= `DCF_PTR_ZERO;
      full_flag_n_o <= 1'b1;
      almost_full_n_o <= 1'b1;
      empty_flag_n_o <= 1'b0;
      almost_empty_n_o <= 1'b0;
      out_reg <= `DCF_DATA_ZERO;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      if (push_edge_i) begin
        full_flag_n_o <= (count_next != `DCF_DEPTH);
        almost_full_n_o <= (count_next < full_thr);
      end
      if (pop_edge_i) begin
        empty_flag_n_o <= (wr_ptr_next != rd_ptr_next);
        almost_empty_n_o <= (count_next > empty_thr);
      end
      if (do_pop) begin
        out_reg <= store_rd_data;
      end else if (ofs_fetch) begin
        out_reg <= {1'b0, ofs_fetch_data};
      end
    end
  end

  // Output pins, registered
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      read_data_o <= `DCF_DATA_ZERO;
      read_data_oe_o <= 1'b0;
    end else begin
      read_data_o <= out_reg;
      read_data_oe_o <= !out_drive_n_i;
    end
  end
endmodule // dcf_top
`default_nettype wire

// ---- testbench/dcf_top_asserts.sv ----
// Port assertions for the buffer top
`timescale 1ns/1ps
`default_nettype none
module dcf_asserts (
  input wire logic sys_clk_i, rst_i, fifo_clear_n_i, push_edge_i, push_enable_n_i,
  input wire logic second_enable_or_load_i, pop_edge_i, pop_enable_a_n_i, pop_enable_b_n_i,
  input wire logic out_drive_n_i, full_flag_n_o, almost_full_n_o, read_data_oe_o,
  input wire logic empty_flag_n_o, almost_empty_n_o, dual_enable_mode_o,
  input wire logic [8:0] write_data_i, read_data_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  clr_flags_a:
    assert property (!fifo_clear_n_i |=> full_flag_n_o && almost_full_n_o
      && !empty_flag_n_o && !almost_empty_n_o) else $error("flags not cleared");
  clr_zero_a:
    assert property (!fifo_clear_n_i [*2] |=> read_data_o == 9'h000) else $error("data not zero");
  push_only_a:
    assert property (!push_edge_i && fifo_clear_n_i |=> $stable({full_flag_n_o, almost_full_n_o}))
      else $error("full flags moved");
  pop_only_a:
    assert property (!pop_edge_i && fifo_clear_n_i
      |=> $stable({empty_flag_n_o, almost_empty_n_o})) else $error("empty flags moved");
  pop_hold_a:
    assert property (fifo_clear_n_i && pop_edge_i && (pop_enable_a_n_i || pop_enable_b_n_i)
      |=> ##1 $stable(read_data_o)) else $error("data moved without enables");
  empty_hold_a:
    assert property (fifo_clear_n_i && pop_edge_i && !empty_flag_n_o
      && (second_enable_or_load_i || dual_enable_mode_o) |=> ##1 $stable(read_data_o))
      else $error("data moved while empty");
  mode_keep_a:
    assert property (fifo_clear_n_i |=> $stable(dual_enable_mode_o)) else $error("mode moved");
  mode_load_a:
    assert property (!fifo_clear_n_i |=> dual_enable_mode_o == $past(second_enable_or_load_i))
      else $error("mode not taken");
  oe_follow_a:
    assert property (1'b1 |=> read_data_oe_o == !$past(out_drive_n_i)) else $error("drive wrong");
  cover property ($fell(full_flag_n_o));
  cover property ($rose(empty_flag_n_o));
  cover property (!dual_enable_mode_o && pop_edge_i && !second_enable_or_load_i);
endmodule // dcf_asserts
bind dcf_top dcf_asserts u_chk (.sys_clk_i, .rst_i, .fifo_clear_n_i, .push_edge_i,
  .push_enable_n_i, .second_enable_or_load_i, .pop_edge_i, .pop_enable_a_n_i,
  .pop_enable_b_n_i, .out_drive_n_i, .full_flag_n_o, .almost_full_n_o, .read_data_oe_o,
  .empty_flag_n_o, .almost_empty_n_o, .dual_enable_mode_o, .write_data_i, .read_data_o);
`default_nettype wire

// ---- testbench/dcf_peer.sv ----
// Producer and consumer edge strobes at independent rates
`timescale 1ns/1ps
`default_nettype none
module dcf_peer (
  input wire logic clk_i, rst_i,
  input wire logic [1:0] wdiv_i, rdiv_i,
  output var logic push_edge_o, pop_edge_o
);
  logic [1:0] wc, rc;
  // Equal rates give coincident edges, unequal ones drift apart
  always @(posedge clk_i or posedge rst_i)
    if (rst_i) begin
      {wc, rc, push_edge_o, pop_edge_o} <= '0;
    end else begin
      wc <= (wc >= wdiv_i) ? 2'h0 : wc + 2'h1;
      rc <= (rc >= rdiv_i) ? 2'h0 : rc + 2'h1;
      push_edge_o <= (wc == 2'h0);
      pop_edge_o <= (rc == 2'h0);
    end
endmodule // dcf_peer
`default_nettype wire

// ---- testbench/tb_dcf_top.sv ----
// Self-checking bench for the buffer top
`timescale 1ns/1ps
`default_nettype none
module tb_dcf_top;
  logic sys_clk_i, rst_i, fifo_clear_n_i, push_edge_i, push_enable_n_i, second_enable_or_load_i;
  logic pop_edge_i, pop_enable_a_n_i, pop_enable_b_n_i, out_drive_n_i, full_flag_n_o;
  logic almost_full_n_o, read_data_oe_o, empty_flag_n_o, almost_empty_n_o, dual_enable_mode_o;
  logic [8:0] write_data_i, read_data_o, cnt, dq[$], eq[$];
  logic [1:0] wdiv, rdiv, v, lp, fp;
  logic [7:0] ofs [4];
  logic ff, af, ef, ae, md, oe;
  int n_errors = 0;
  int checks_done = 0;
  wire pp = pop_edge_i & ~pop_enable_a_n_i & ~pop_enable_b_n_i;
  wire fe = pp & ~md & ~second_enable_or_load_i;
  wire rd = pp & ef & ~fe;
  wire wr = push_edge_i & ~push_enable_n_i & second_enable_or_load_i & ff;
  wire ld = push_edge_i & ~push_enable_n_i & ~second_enable_or_load_i & ~md;
  wire [8:0] nx = cnt + 9'(wr) - 9'(rd);
  dcf_top u_dut (.sys_clk_i, .rst_i, .fifo_clear_n_i, .push_edge_i, .push_enable_n_i,
    .second_enable_or_load_i, .write_data_i, .full_flag_n_o, .almost_full_n_o, .pop_edge_i,
    .pop_enable_a_n_i, .pop_enable_b_n_i, .out_drive_n_i, .read_data_o, .read_data_oe_o,
    .empty_flag_n_o, .almost_empty_n_o, .dual_enable_mode_o);
  dcf_peer u_peer (.clk_i(sys_clk_i), .rst_i, .wdiv_i(wdiv), .rdiv_i(rdiv),
    .push_edge_o(push_edge_i), .pop_edge_o(pop_edge_i));
  always #2.5 sys_clk_i = ~sys_clk_i;
  // Expected flags, offsets and read data
  always @(posedge sys_clk_i or posedge rst_i)
    if (rst_i || !fifo_clear_n_i) begin
      cnt <= '0;
      {ff, af, ef, ae, lp, fp} <= 8'hc0;
      ofs <= '{8'h07, 8'h00, 8'h07, 8'h00};
      md <= !rst_i && second_enable_or_load_i;
      oe <= !rst_i && !out_drive_n_i;
      v <= {1'b0, !rst_i};
      dq.delete();
      eq.delete();
      if (!rst_i) eq.push_back('0);
    end else begin
      cnt <= nx;
      oe <= !out_drive_n_i;
      v <= {v[0], rd | fe};
      if (wr) dq.push_back(write_data_i);
      if (rd) eq.push_back(dq.pop_front());
      if (push_edge_i) begin
        ff <= nx != 9'h100;
        af <= nx < 9'h100 - {1'b0, ofs[2]};
      end
      if (pop_edge_i) begin
        ef <= nx != 9'h000;
        ae <= nx > {1'b0, ofs[0]};
      end
      if (ld) begin
        ofs[lp] <= write_data_i[7:0];
        lp <= lp + 2'h1;
      end
      if (fe) begin
        eq.push_back({1'b0, ofs[fp]});
        fp <= fp + 2'h1;
      end
    end
  task chk(input logic [8:0] g, e);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  always @(negedge sys_clk_i) if (!rst_i) begin
    chk(9'({full_flag_n_o, almost_full_n_o, empty_flag_n_o, almost_empty_n_o, read_data_oe_o,
      dual_enable_mode_o}), 9'({ff, af, ef, ae, oe, md}));
    if (v[1]) chk(read_data_o, eq.pop_front());
  end
  // Control word is clear, drive, pin, push enable, pop enables
  task st(input logic [5:0] c, input logic [3:0] d, input int n);
    {fifo_clear_n_i, out_drive_n_i, second_enable_or_load_i, push_enable_n_i,
      pop_enable_a_n_i, pop_enable_b_n_i} = c;
    {wdiv, rdiv} = d;
    repeat (n) begin
      @(negedge sys_clk_i);
      write_data_i = 9'($urandom);
    end
  endtask
  task results;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    sys_clk_i = 0;
    rst_i = 1;
    write_data_i = '0;
    void'($urandom(32'h93e6));
    st(6'b100111, 4'h0, 6);
    rst_i = 0;
    st(6'b001111, 4'h0, 2);
    st(6'b101011, 4'h0, 270);
    st(6'b101000, 4'h6, 600);
    st(6'b101000, 4'hc, 400);
    repeat (600) st({2'b10, 4'($urandom)}, 4'h5, 1);
    st(6'b111100, 4'h0, 300);
    st(6'b000111, 4'h0, 2);
    st(6'b100100, 4'h0, 4);
    st(6'b100011, 4'h0, 2);
    st(6'b101111, 4'h0, 2);
    st(6'b100111, 4'h0, 2);
    st(6'b100011, 4'h0, 3);
    st(6'b100100, 4'h0, 5);
    st(6'b101011, 4'h0, 270);
    st(6'b101100, 4'h0, 300);
    results();
  end
endmodule // tb_dcf_top
`default_nettype wire
